// File: core/dgc_smoother_ctrl.sv
// per-channel jitter smoother control registers on AXI4-Lite
// assumes a gapped transmit clock from mapper logic on the link side
//
// Functional notes
// - hi bandwidth bit 0 with lo bit 1 selects narrow de-sync bandwidth
// - path select bit 1 places the smoother in the transmit path
// - recovery disable 0 keeps fast protection-switch recovery active
// - recovery disable 1 turns fast recovery off; its use is optional
// - twelve control registers at index m7, m in 0-5 and 8-D
// - gaps up to 59 bit times without clock pulses are tolerated
`timescale 1ns/1ns
module dgc_smoother_ctrl #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                        aclk,
  input  wire logic                        aclk_en,
  input  wire logic                        aresetn,
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        tx_clk,
  input  wire logic                        tx_data,
  output logic                             tx_bit,
  output logic [dgc_pkg::NUM_CH-1:0]       narrow_bw_mode,
  output logic [dgc_pkg::NUM_CH-1:0]       smoother_in_tx,
  output logic [dgc_pkg::NUM_CH-1:0]       fast_recovery_en,
  output logic [dgc_pkg::NUM_CH-1:0]       smoother_reset
);
  import dgc_pkg::*;

  // returns {hit, channel} for a register index
  function automatic logic [CH_W:0] dgc_decode(input logic [IDX_W-1:0] idx);
    logic [3:0] grp;
    grp = idx[7:4];
    dgc_decode = '0;
    if (idx[3:0] == CTRL_LO_NIBBLE) begin
      if (grp <= GRP0_LAST) begin
        dgc_decode = {1'b1, grp};
      end else if (grp >= GRP1_FIRST && grp <= GRP1_LAST) begin
        dgc_decode = {1'b1, grp - GRP1_SKIP};
      end
    end
  endfunction : dgc_decode

  function automatic logic [CNT_W-1:0] dgc_gray2bin(
    input logic [CNT_W-1:0] g
  );
    logic [CNT_W-1:0] b;
    b = '0;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    dgc_gray2bin = b;
  endfunction : dgc_gray2bin

  logic [CTRL_W-1:0]  ctrl_reg [NUM_CH];
  logic               aw_held_reg;
  logic               w_held_reg;
  logic [IDX_W-1:0]   wr_idx_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               wr_do;
  logic [CH_W:0]      wr_dec;
  logic               wr_hit;
  logic [CH_W-1:0]    wr_ch;
  logic [CH_W:0]      rd_dec;
  logic [IDX_W-1:0]   rd_idx;
  logic [CNT_W-1:0]   pulse_gray;
  logic [CNT_W-1:0]   gray_meta_reg;
  logic [CNT_W-1:0]   gray_sync_reg;
  logic [CNT_W-1:0]   pulse_count;

  ////////////////////////////////////////////////////////////////////////////
  // link side capture and gray-coded count crossing
  // count crosses as gray code, so a torn sample is off by one at most

  dgc_link_capture #(
    .CNT_W      (CNT_W)
  ) u_link (
    .tx_clk     (tx_clk),
    .aresetn    (aresetn),
    .tx_data    (tx_data),
    .tx_bit     (tx_bit),
    .pulse_gray (pulse_gray)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gray_meta_reg <= '0;
      gray_sync_reg <= '0;
    end else if (aclk_en) begin
      gray_meta_reg <= pulse_gray;
      gray_sync_reg <= gray_meta_reg;
    end
  end

  assign pulse_count = dgc_gray2bin(gray_sync_reg);

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  // readies stay low while a response waits: one write in flight

  assign s_axi_awready = aclk_en && !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = aclk_en && !w_held_reg && !s_axi_bvalid;
  assign wr_do         = aclk_en && aw_held_reg && w_held_reg
                         && !s_axi_bvalid;
  assign wr_dec        = dgc_decode(wr_idx_reg);
  assign wr_hit        = wr_dec[CH_W];
  assign wr_ch         = wr_dec[CH_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      wr_idx_reg  <= '0;
    end else if (aclk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        wr_idx_reg  <= s_axi_awaddr[IDX_LSB +: IDX_W];
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (aclk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aclk_en) begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // smoother control registers, byte lane 0 only

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_reg[c] <= CTRL_RESET;
      end
    end else if (aclk_en && wr_do && wr_hit && wstrb_reg[0]) begin
      ctrl_reg[wr_ch] <= wdata_reg[CTRL_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      narrow_bw_mode   <= '0;
      smoother_in_tx   <= '0;
      fast_recovery_en <= '1; // control reset leaves recovery on
      smoother_reset   <= '0;
    end else if (aclk_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        narrow_bw_mode[c]   <= !ctrl_reg[c][BW_HI_BIT]
                               && ctrl_reg[c][BW_LO_BIT];
        smoother_in_tx[c]   <= ctrl_reg[c][PATH_BIT];
        fast_recovery_en[c] <= !ctrl_reg[c][FRD_BIT];
        smoother_reset[c]   <= ctrl_reg[c][SMR_RST_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: answer one cycle after the address is taken

  assign s_axi_arready = aclk_en && !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[IDX_LSB +: IDX_W];
  assign rd_dec        = dgc_decode(rd_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (aclk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= 32'h0000_0000;
        s_axi_rresp  <= RESP_OKAY;
        if (rd_dec[CH_W]) begin
          s_axi_rdata[CTRL_W-1:0] <= ctrl_reg[rd_dec[CH_W-1:0]];
        end else if (rd_idx == STATUS_IDX) begin
          s_axi_rdata[CNT_W-1:0] <= pulse_count;
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_wr_ch0;
    wr_do && wr_hit && wr_ch == 4'h0 && wstrb_reg[0];
  endsequence

  sequence s_both_taken;
    aw_held_reg && w_held_reg && !s_axi_bvalid && aclk_en;
  endsequence

  a_bw_narrow_set: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_ch0 and (wdata_reg[2:0] == 3'b001) |-> ##2 narrow_bw_mode[0])
    else $error("narrow bandwidth not selected after write");

  a_bw_wide_set: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_ch0 and (wdata_reg[2] == 1'b1) |-> ##2 !narrow_bw_mode[0])
    else $error("narrow bandwidth selected with high bit set");

  a_path_tx_set: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_ch0 |-> ##2 smoother_in_tx[0] == $past(wdata_reg[1], 2))
    else $error("smoother path does not follow written bit");

  a_recovery_on_set: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_ch0 and (wdata_reg[4] == 1'b0) |-> ##2 fast_recovery_en[0])
    else $error("fast recovery not enabled");

  a_recovery_off_set: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_ch0 and (wdata_reg[4] == 1'b1) |-> ##2 !fast_recovery_en[0])
    else $error("fast recovery not disabled");

  a_unmapped_resp: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_both_taken and !wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  a_write_resp_hold: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");

  a_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_axi_arvalid && s_axi_arready && rd_dec[CH_W]
    |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY
        && s_axi_rdata[31:CTRL_W] == '0)
    else $error("control read answer wrong");

  a_ctrl_hold: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    !wr_do [*2] |=> $stable(smoother_in_tx))
    else $error("path select changed without a write");

  sequence s_wr_mapped;
    wr_do && wr_hit;
  endsequence

  a_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_mapped |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("mapped write not answered okay");

  a_ctrl_store: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_mapped and wstrb_reg[0]
    |=> ctrl_reg[wr_ch] == wdata_reg[CTRL_W-1:0])
    else $error("control register did not take written value");

  a_strobe_masked: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_mapped and !wstrb_reg[0] |=> $stable(ctrl_reg[wr_ch]))
    else $error("control register changed with byte lane 0 off");

  a_reset_level_set: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_wr_ch0 |-> ##2 smoother_reset[0] == $past(wdata_reg[SMR_RST_BIT], 2))
    else $error("smoother reset does not follow written bit");

  a_unmapped_read: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_axi_arvalid && s_axi_arready && !rd_dec[CH_W] && rd_idx != STATUS_IDX
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");

  a_status_read: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_axi_arvalid && s_axi_arready && rd_idx == STATUS_IDX
    |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY
        && s_axi_rdata[31:CNT_W] == '0)
    else $error("status read answer wrong");

  a_read_resp_hold: assert property (
    @(posedge aclk) disable iff (!aresetn || !aclk_en)
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped before ready");

  a_freeze_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !aclk_en |=> $stable(narrow_bw_mode) && $stable(s_axi_bvalid)
                 && $stable(s_axi_rvalid))
    else $error("state moved while clock enable low");

endmodule : dgc_smoother_ctrl

// File: core/dgc_pkg.sv
// constants shared by the de-synchronizer smoother control block
// assumes a 32-bit AXI4-Lite register bus and one gapped transmit link
package dgc_pkg;

  localparam int unsigned NUM_CH         = 12;
  localparam int unsigned CH_W           = 4;
  localparam int unsigned IDX_W          = 8;
  localparam int unsigned IDX_LSB        = 2;
  localparam int unsigned CNT_W          = 16;

  // register index: high nibble selects channel group, low nibble fixed
  localparam logic [3:0]  CTRL_LO_NIBBLE = 4'h7;
  localparam logic [3:0]  GRP0_LAST      = 4'h5;
  localparam logic [3:0]  GRP1_FIRST     = 4'h8;
  localparam logic [3:0]  GRP1_LAST      = 4'hd;
  localparam logic [3:0]  GRP1_SKIP      = 4'h2;
  localparam logic [7:0]  STATUS_IDX     = 8'h70;

  // smoother control field positions
  localparam int unsigned BW_LO_BIT      = 0;
  localparam int unsigned PATH_BIT       = 1;
  localparam int unsigned BW_HI_BIT      = 2;
  localparam int unsigned SMR_RST_BIT    = 3;
  localparam int unsigned FRD_BIT        = 4;
  localparam int unsigned CTRL_W         = 5;
  localparam logic [4:0]  CTRL_RESET     = 5'h00;

  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // longest run of missing transmit clock pulses the smoother tolerates
  localparam int unsigned MAX_GAP_BITS   = 59;

endpackage : dgc_pkg

// File: core/dgc_link_capture.sv
// link-side capture of the gapped transmit clock and data
// assumes tx_clk is the mapper's gapped clock; it may stop between bursts
`timescale 1ns/1ns
module dgc_link_capture #(
  parameter int unsigned CNT_W = dgc_pkg::CNT_W
) (
  input  wire logic             tx_clk,
  input  wire logic             aresetn,
  input  wire logic             tx_data,
  output logic                  tx_bit,
  output logic [CNT_W-1:0]      pulse_gray
);
  import dgc_pkg::*;

  logic             rst_meta_n;
  logic             rst_n;
  logic [CNT_W-1:0] pulse_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset level brought into the link domain
  always_ff @(posedge tx_clk) begin
    rst_meta_n <= aresetn;
    rst_n      <= rst_meta_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one data bit per clock pulse; nothing advances during a gap
  always_ff @(posedge tx_clk) begin
    if (!rst_n) begin
      tx_bit <= 1'b0;
    end else begin
      tx_bit <= tx_data;
    end
  end

  // pulse count leaves the domain gray coded
  always_ff @(posedge tx_clk) begin
    if (!rst_n) begin
      pulse_cnt_reg <= '0;
      pulse_gray    <= '0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
      pulse_gray    <= pulse_cnt_reg ^ (pulse_cnt_reg >> 1);
    end
  end

endmodule : dgc_link_capture

// File: tb/dgc_mapper_model.sv
// mapper stand-in: regular gapped transmit clock and data
// assumes the caller paces it; the clock stands still between frames
`timescale 1ns/1ns
module dgc_mapper_model (
  output logic tx_clk,
  output logic tx_data
);
  logic last_bit;

  initial begin
    tx_clk   = 1'b0;
    tx_data  = 1'b0;
    last_bit = 1'b0;
  end

  // one 15 ns reference slot: a pulse or an empty period
  task automatic slot(input bit pulse);
    if (pulse) begin
      tx_data  = 1'($urandom);
      last_bit = tx_data;
    end
    #7 tx_clk = pulse;
    #8 tx_clk = 1'b0;
  endtask : slot

  task automatic group(input int n, input bit gap);
    repeat (n) slot(1'b1);
    if (gap) slot(1'b0);
  endtask : group

  task automatic pattern(input bit b);
    repeat (63) group(7, 1'b1);
    repeat (b ? 35 : 36) group(5, 1'b1);
    if (b) group(6, 1'b0);
  endtask : pattern

  // pre-processed stream: A, A, B
  task automatic super_pattern();
    pattern(1'b0);
    pattern(1'b0);
    pattern(1'b1);
  endtask : super_pattern

  // released data line shows the inverse of the last bit
  task automatic idle(input int n);
    tx_data = ~last_bit;
    #(15 * n);
  endtask : idle
endmodule : dgc_mapper_model

// File: tb/tb_top.sv
// self-checking bench for the smoother control block
// assumes AXI4-Lite master here and the mapper model on the link
`timescale 1ns/1ns
module tb_top;
  import dgc_pkg::*;
  logic              aclk, aclk_en, aresetn, tx_clk, tx_data, tx_bit;
  logic [11:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd_last;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready;
  logic [NUM_CH-1:0] narrow_bw_mode, smoother_in_tx, fast_recovery_en;
  logic [NUM_CH-1:0] smoother_reset;
  logic [4:0]        exp_ctrl [NUM_CH];
  logic [1:0]        bq [$];
  logic [65:0]       rq [$];
  int                err_total, num_checks;

  dgc_smoother_ctrl dut_u (
    .aclk(aclk), .aclk_en(aclk_en), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_clk(tx_clk), .tx_data(tx_data),
    .tx_bit(tx_bit), .narrow_bw_mode(narrow_bw_mode),
    .smoother_in_tx(smoother_in_tx), .fast_recovery_en(fast_recovery_en),
    .smoother_reset(smoother_reset)
  );
  dgc_mapper_model map_u (.tx_clk(tx_clk), .tx_data(tx_data));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t output %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_rd(input logic [65:0] e);
    num_checks++;
    if ((s_axi_rdata & e[63:32]) !== e[31:0] || s_axi_rresp !== e[65:64]) begin
      err_total++;
      $display("ERROR %0t read %h/%h expected %h", $time, s_axi_rdata,
               s_axi_rresp, e);
    end
  endtask : cmp_rd

  task automatic cmp_wr(input logic [1:0] e);
    num_checks++;
    if (s_axi_bresp !== e) begin
      err_total++;
      $display("ERROR %0t bresp %h expected %h", $time, s_axi_bresp, e);
    end
  endtask : cmp_wr

  // scoreboard: oldest note against each response
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp_wr(bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) cmp_rd(rq.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    bit ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back(er);
    s_axi_bready  <= 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat ($urandom_range(3)) @(posedge aclk);
    s_axi_bready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [65:0] e);
    rq.push_back(e);
    s_axi_rready  <= 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(3)) @(posedge aclk);
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_last = s_axi_rdata;
  endtask : rd

  function automatic logic [11:0] ch_addr(input int c);
    logic [3:0] m;
    m = (c < 6) ? 4'(c) : 4'(c + 2);
    return {2'b00, m, CTRL_LO_NIBBLE, 2'b00};
  endfunction : ch_addr

  task automatic chk_outs();
    logic [11:0] nb, px, fr, sr;
    logic [65:0] e;
    repeat (2) @(posedge aclk);
    for (int c = 0; c < NUM_CH; c++) begin
      nb[c] = ~exp_ctrl[c][BW_HI_BIT] & exp_ctrl[c][BW_LO_BIT];
      px[c] = exp_ctrl[c][PATH_BIT];
      fr[c] = ~exp_ctrl[c][FRD_BIT];
      sr[c] = exp_ctrl[c][SMR_RST_BIT];
    end
    cmp_val(32'(narrow_bw_mode), 32'(nb));
    cmp_val(32'(smoother_in_tx), 32'(px));
    cmp_val(32'(fast_recovery_en), 32'(fr));
    cmp_val(32'(smoother_reset), 32'(sr));
    for (int c = 0; c < NUM_CH; c++) begin
      e = {RESP_OKAY, 32'hffff_ffff, 27'h0, exp_ctrl[c]};
      rd(ch_addr(c), e);
    end
  endtask : chk_outs

  // link side needs clock edges while reset is low
  task automatic reset_dut();
    aresetn <= 1'b0;
    fork
      repeat (6) @(posedge aclk);
      repeat (6) map_u.slot(1'b1);
    join
    aresetn <= 1'b1;
    foreach (exp_ctrl[c]) exp_ctrl[c] = CTRL_RESET;
    @(posedge aclk);
  endtask : reset_dut

  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400_000;
    err_total++;
    final_report();
  end

  initial begin
    logic [31:0] v;
    logic [3:0]  s;
    logic [15:0] base;
    logic [11:0] bad [3];
    bad = '{12'h19c, 12'h39c, 12'h018};
    void'($urandom(32'h0000_96aa));
    {aclk_en, s_axi_bready, s_axi_rready} <= 3'b100;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'b000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    reset_dut();
    chk_outs();
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        v = $urandom;
        if (p < 2) v[4:0] = p ? 5'h13 : 5'h05;
        s = (p == 2 && c == 0) ? 4'he : 4'hf;
        if (s[0]) exp_ctrl[c] = v[4:0];
        wr(ch_addr(c), v, s, RESP_OKAY);
      end
      chk_outs();
    end
    // a write stalls while the clock enable is low
    v = $urandom;
    exp_ctrl[3] = v[4:0];
    aclk_en <= 1'b0;
    fork
      wr(ch_addr(3), v, 4'hf, RESP_OKAY);
      begin
        repeat (3) @(posedge aclk);
        aclk_en <= 1'b1;
      end
    join
    foreach (bad[i]) begin
      wr(bad[i], $urandom, 4'hf, RESP_SLVERR);
      rd(bad[i], {RESP_SLVERR, 32'hffff_ffff, 32'h0});
    end
    chk_outs();
    repeat (4) map_u.slot(1'b1);
    repeat (10) @(posedge aclk);
    rd({2'b00, STATUS_IDX, 2'b00}, {RESP_OKAY, 64'h0});
    base = rd_last[15:0];
    map_u.super_pattern();
    map_u.idle(MAX_GAP_BITS);
    map_u.super_pattern();
    map_u.idle(4);
    repeat (10) @(posedge aclk);
    v = 32'(base + 16'(2 * (2 * (63 * 7 + 36 * 5) + 63 * 7 + 35 * 5 + 6)));
    rd({2'b00, STATUS_IDX, 2'b00}, {RESP_OKAY, 32'h0000_ffff, v});
    cmp_val(32'(tx_bit), 32'(map_u.last_bit));
    reset_dut();
    chk_outs();
    final_report();
  end
endmodule : tb_top
